// >>> verilog/cxm_pkg.sv
// cxm_pkg: constants, carriers and helpers shared by the cross-connect matrix files
// assumes one 250 MHz clock domain; no software-visible registers in this block
package cxm_pkg;

    // matrix dimensions
    localparam int STS_PORTS      = 288;
    localparam int STS_XC_MAX     = 144;
    localparam int VT_PORTS       = 672;
    localparam int VT_LOGICAL_STS = 24;
    localparam int VT_PER_STS     = 28;
    localparam int VT_GROUPS      = 7;
    localparam int VT_XC_MAX      = 336;

    // slot bandwidth plan: high-speed slots first, then the low-speed ones
    localparam int SLOTS          = 12;
    localparam int HS_SLOTS       = 4;
    localparam int HS_SLOT_WIDTH  = 48;
    localparam int LS_SLOT_WIDTH  = 12;

    // data path
    localparam int DATA_W         = 8;
    localparam int FIFO_DEPTH     = 8;

    // each bidirectional cross-connect takes two one-way map entries
    localparam logic [9:0] STS_ENTRY_LIMIT = 10'(2 * STS_XC_MAX);
    localparam logic [9:0] VT_ENTRY_LIMIT  = 10'(2 * VT_XC_MAX);

    // reset values
    localparam logic       FAIL_LED_RST  = 1'b1;
    localparam logic [9:0] CNT_RST       = 10'h000;

    typedef enum logic [2:0] {
        SC_HOLD = 3'b001,
        SC_STS  = 3'b010,
        SC_VT   = 3'b100
    } cxm_scan_e;

    // connection setup request from the controller
    typedef struct packed {
        logic       isVt;
        logic       connect;
        logic [3:0] slot;
        logic [8:0] dstPort;
        logic [4:0] dstVt;
        logic [8:0] srcPort;
        logic [4:0] srcVt;
    } cxm_cfg_s;

    // incoming STS-1 timeslot byte
    typedef struct packed {
        logic [8:0]        port;
        logic [DATA_W-1:0] data;
    } cxm_sts_in_s;

    // incoming VT1.5 tributary byte
    typedef struct packed {
        logic [4:0]        sts;
        logic [4:0]        vtNum;
        logic [DATA_W-1:0] data;
    } cxm_vt_in_s;

    // switched word leaving the matrix
    typedef struct packed {
        logic              isVt;
        logic [8:0]        port;
        logic [4:0]        vtNum;
        logic [2:0]        group;
        logic [2:0]        position;
        logic [DATA_W-1:0] data;
    } cxm_word_s;

    localparam int WORD_W = $bits(cxm_word_s);

    // whole state of the top module
    typedef struct packed {
        cxm_scan_e            scan;
        logic [STS_PORTS-1:0] stsEn;
        logic [VT_PORTS-1:0]  vtEn;
        logic [9:0]           stsCnt;
        logic [9:0]           vtCnt;
        logic [8:0]           scanIdx;
        logic [4:0]           scanSts;
        logic [4:0]           scanVt;
        logic                 outValid;
        cxm_word_s            outWord;
        logic                 cfgAck;
        logic                 cfgErr;
        logic                 failLed;
        logic                 actGreen;
        logic                 stbyAmber;
    } cxm_state_s;

    // linear VT index from logical STS and tributary number 1..28
    function automatic logic [9:0] vtIndex(input logic [4:0] sts, input logic [4:0] num);
        vtIndex = 10'(sts) * 10'(VT_PER_STS) + 10'(num) - 10'h001;
    endfunction

    // true when an STS port lies inside the bandwidth given to a slot
    function automatic logic slotOwns(input logic [3:0] slot, input logic [8:0] port);
        logic [9:0] base;
        logic [9:0] width;
        base  = 10'h000;
        width = 10'h000;
        if (slot < 4'(HS_SLOTS))
        begin
            base  = 10'(slot) * 10'(HS_SLOT_WIDTH);
            width = 10'(HS_SLOT_WIDTH);
        end
        else if (slot < 4'(SLOTS))
        begin
            base  = 10'(HS_SLOTS * HS_SLOT_WIDTH) + (10'(slot) - 10'(HS_SLOTS)) * 10'(LS_SLOT_WIDTH);
            width = 10'(LS_SLOT_WIDTH);
        end
        slotOwns = (10'(port) >= base) && (10'(port) < base + width);
    endfunction

endpackage

// >>> verilog/cxm_fifo.sv
// cxm_fifo: small synchronous FIFO with valid/ready on both sides
// assumes the caller freezes it with ce; DEPTH need not be a power of two
`timescale 1ns/1ps
module cxm_fifo
    import cxm_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } cxm_fifo_state_s;

    cxm_fifo_state_s s_reg;
    cxm_fifo_state_s s_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    // honest flags straight from the occupancy count
    assign inReady  = (s_reg.cnt != (AW+1)'(DEPTH));
    assign outValid = (s_reg.cnt != '0);
    assign outData  = mem[s_reg.rd];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // pointer and count update, wrap at DEPTH
    always_comb
    begin
        s_next = s_reg;
        if (push)
            s_next.wr = (s_reg.wr == AW'(DEPTH - 1)) ? '0 : s_reg.wr + 1'b1;
        if (pop)
            s_next.rd = (s_reg.rd == AW'(DEPTH - 1)) ? '0 : s_reg.rd + 1'b1;
        if (push && !pop)
            s_next.cnt = s_reg.cnt + 1'b1;
        else if (pop && !push)
            s_next.cnt = s_reg.cnt - 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_reg <= '0;
        else if (ce)
            s_reg <= s_next;
    end

    // storage needs no reset, the count guards it
    always_ff @(posedge clk)
    begin
        if (ce && push)
            mem[s_reg.wr] <= inData;
    end

endmodule // cxm_fifo

// >>> verilog/cxm_vt_map.sv
// cxm_vt_map: turns logical STS and tributary number into index and group/position
// assumes tributaries are numbered 1..28; purely combinational
`timescale 1ns/1ps
module cxm_vt_map
    import cxm_pkg::*;
(
    input  wire logic [4:0] sts,
    input  wire logic [4:0] vtNum,
    output logic [9:0]      index,
    output logic [2:0]      group,
    output logic [2:0]      position,
    output logic            ok
);
    logic [4:0] n1;

    // groups interleave: consecutive numbers step through the seven groups
    assign n1       = vtNum - 5'h01;
    assign group    = 3'(n1 % 5'(VT_GROUPS)) + 3'h1;
    assign position = 3'(n1 / 5'(VT_GROUPS)) + 3'h1;
    assign index    = vtIndex(sts, vtNum);
    assign ok       = (vtNum >= 5'h01) && (vtNum <= 5'(VT_PER_STS)) && (sts < 5'(VT_LOGICAL_STS));

endmodule // cxm_vt_map

// >>> verilog/cxm_top.sv
// cxm_top: time-division STS-1 and VT1.5 cross-connect with connection maps
// assumes all inputs synchronous to clk; the controller writes the maps, traffic
// cards stream bytes in and take switched words out through a valid/ready port
// limitation: a word carries only the latest byte of its source
`timescale 1ns/1ps
module cxm_top
    import cxm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        cfgValid,
    input  wire cxm_cfg_s    cfgReq,
    output logic             cfgAck,
    output logic             cfgErr,
    input  wire logic        stsInValid,
    input  wire cxm_sts_in_s stsIn,
    input  wire logic        vtInValid,
    input  wire cxm_vt_in_s  vtIn,
    output logic             outValid,
    input  wire logic        outReady,
    output cxm_word_s        outWord,
    input  wire logic        procReady,
    input  wire logic        activeSel,
    output logic             failLed,
    output logic             actGreen,
    output logic             stbyAmber
);
    cxm_state_s s_reg;
    cxm_state_s s_next;

    // connection and data memories; one source per destination,
    // so broadcast is free and no connection blocks another
    logic [8:0]        stsSrc  [STS_PORTS];
    logic [9:0]        vtSrc   [VT_PORTS];
    logic [DATA_W-1:0] stsData [STS_PORTS];
    logic [DATA_W-1:0] vtData  [VT_PORTS];

    // traffic-side VT decode
    logic [9:0] vtInIdx;
    logic       vtInOk;

    // scanner-side VT decode
    logic [9:0] scanVtIdx;
    logic [2:0] scanGroup;
    logic [2:0] scanPos;
    logic       scanVtOk;

    // setup decode
    logic [9:0] cfgDstIdx;
    logic [9:0] cfgSrcIdx;
    logic       cfgLegal;
    logic       cfgWasEn;
    logic       cfgFull;
    logic       cfgTake;
    logic       mapWrSts;
    logic       mapWrVt;

    // scanner to FIFO
    logic       pushValid;
    cxm_word_s  pushWord;
    logic       pushReady;
    logic       fifoValid;
    logic       fifoReady;
    cxm_word_s  fifoWord;
    logic       scanEn;

    // incoming tributary address check and linear index
    cxm_vt_map u_vt_in_map
    (
        .sts      (vtIn.sts),
        .vtNum    (vtIn.vtNum),
        .index    (vtInIdx),
        .group    (),
        .position (),
        .ok       (vtInOk)
    );

    // scanner tributary gives the group and position tagged on each VT word
    cxm_vt_map u_vt_scan_map
    (
        .sts      (s_reg.scanSts),
        .vtNum    (s_reg.scanVt),
        .index    (scanVtIdx),
        .group    (scanGroup),
        .position (scanPos),
        .ok       (scanVtOk)
    );

    // setup request decode: slot ownership for STS, tributary bounds for VT
    // a refused request touches neither maps nor counts
    always_comb
    begin
        cfgDstIdx = 10'h000;
        cfgSrcIdx = 10'h000;
        cfgLegal  = 1'b0;
        cfgWasEn  = 1'b0;
        cfgFull   = 1'b0;
        if (!cfgReq.isVt)
        begin
            cfgDstIdx = 10'(cfgReq.dstPort);
            cfgSrcIdx = 10'(cfgReq.srcPort);
            cfgLegal  = slotOwns(cfgReq.slot, cfgReq.dstPort)
                        && (cfgReq.srcPort < 9'(STS_PORTS));
            if (cfgLegal)
                cfgWasEn = s_reg.stsEn[cfgReq.dstPort];
            cfgFull = (s_reg.stsCnt >= STS_ENTRY_LIMIT);
        end
        else
        begin
            cfgDstIdx = vtIndex(5'(cfgReq.dstPort), cfgReq.dstVt);
            cfgSrcIdx = vtIndex(5'(cfgReq.srcPort), cfgReq.srcVt);
            cfgLegal  = (cfgReq.dstPort < 9'(VT_LOGICAL_STS)) && (cfgReq.dstVt >= 5'h01)
                        && (cfgReq.dstVt <= 5'(VT_PER_STS))
                        && (cfgReq.srcPort < 9'(VT_LOGICAL_STS)) && (cfgReq.srcVt >= 5'h01)
                        && (cfgReq.srcVt <= 5'(VT_PER_STS));
            if (cfgLegal)
                cfgWasEn = s_reg.vtEn[cfgDstIdx];
            cfgFull = (s_reg.vtCnt >= VT_ENTRY_LIMIT);
        end
    end

    // a reconnect of an already used destination never counts against the limit
    assign cfgTake  = cfgValid && cfgLegal && !(cfgReq.connect && !cfgWasEn && cfgFull);
    assign mapWrSts = cfgTake && cfgReq.connect && !cfgReq.isVt;
    assign mapWrVt  = cfgTake && cfgReq.connect && cfgReq.isVt;

    // scanner only runs while selected active
    // going active again restarts the scan at STS 0
    assign scanEn   = activeSel && (s_reg.scan != SC_HOLD);

    // present the current destination to the FIFO when it has a source
    // a map write shows at the next visit of that destination
    always_comb
    begin
        pushValid = 1'b0;
        pushWord  = '0;
        if (scanEn && s_reg.scan == SC_STS)
        begin
            pushValid         = s_reg.stsEn[s_reg.scanIdx];
            pushWord.isVt     = 1'b0;
            pushWord.port     = s_reg.scanIdx;
            pushWord.data     = stsData[stsSrc[s_reg.scanIdx]];
        end
        else if (scanEn && s_reg.scan == SC_VT && scanVtOk)
        begin
            pushValid         = s_reg.vtEn[scanVtIdx];
            pushWord.isVt     = 1'b1;
            pushWord.port     = 9'(s_reg.scanSts);
            pushWord.vtNum    = s_reg.scanVt;
            pushWord.group    = scanGroup;
            pushWord.position = scanPos;
            pushWord.data     = vtData[vtSrc[scanVtIdx]];
        end
    end

    // output stage drains the FIFO only while active, so words wait in it through standby
    // the FIFO lets a fixed scan meet a card not always ready
    assign fifoReady = activeSel && (!s_reg.outValid || outReady);

    cxm_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo
    (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .inData   (pushWord),
        .outValid (fifoValid),
        .outReady (fifoReady),
        .outData  (fifoWord)
    );

    // next state of the whole block
    always_comb
    begin
        s_next        = s_reg;
        s_next.cfgAck = 1'b0;
        s_next.cfgErr = 1'b0;

        // map maintenance: enable bits and entry counts
        if (cfgValid)
        begin
            s_next.cfgAck = cfgTake;
            s_next.cfgErr = !cfgTake;
        end
        if (cfgTake && !cfgReq.isVt)
        begin
            s_next.stsEn[cfgDstIdx[8:0]] = cfgReq.connect;
            if (cfgReq.connect && !cfgWasEn)
                s_next.stsCnt = s_reg.stsCnt + 10'h001;
            else if (!cfgReq.connect && cfgWasEn)
                s_next.stsCnt = s_reg.stsCnt - 10'h001;
        end
        if (cfgTake && cfgReq.isVt)
        begin
            s_next.vtEn[cfgDstIdx] = cfgReq.connect;
            if (cfgReq.connect && !cfgWasEn)
                s_next.vtCnt = s_reg.vtCnt + 10'h001;
            else if (!cfgReq.connect && cfgWasEn)
                s_next.vtCnt = s_reg.vtCnt - 10'h001;
        end

        // scan walk: all STS destinations, then all tributaries, then again;
        // a connected destination waits for FIFO room, an idle one is skipped
        // an unstalled sweep takes 288 + 672 cycles
        case (s_reg.scan)
            SC_HOLD:
            begin
                if (activeSel)
                begin
                    s_next.scan    = SC_STS;
                    s_next.scanIdx = 9'h000;
                end
            end
            SC_STS:
            begin
                if (!activeSel)
                    s_next.scan = SC_HOLD;
                else if (!pushValid || pushReady)
                begin
                    if (s_reg.scanIdx == 9'(STS_PORTS - 1))
                    begin
                        s_next.scan    = SC_VT;
                        s_next.scanSts = 5'h00;
                        s_next.scanVt  = 5'h01;
                    end
                    else
                        s_next.scanIdx = s_reg.scanIdx + 9'h001;
                end
            end
            SC_VT:
            begin
                if (!activeSel)
                    s_next.scan = SC_HOLD;
                else if (!pushValid || pushReady)
                begin
                    if (s_reg.scanVt >= 5'(VT_PER_STS))
                    begin
                        s_next.scanVt = 5'h01;
                        if (s_reg.scanSts >= 5'(VT_LOGICAL_STS - 1))
                        begin
                            s_next.scan    = SC_STS;
                            s_next.scanIdx = 9'h000;
                            s_next.scanSts = 5'h00;
                        end
                        else
                            s_next.scanSts = s_reg.scanSts + 5'h01;
                    end
                    else
                        s_next.scanVt = s_reg.scanVt + 5'h01;
                end
            end
            default:
                s_next.scan = SC_HOLD;
        endcase

        // output register: in standby the held word is dropped, not driven
        // FIFO words survive standby and leave first on return
        if (!activeSel)
            s_next.outValid = 1'b0;
        else if (fifoReady)
        begin
            s_next.outValid = fifoValid;
            if (fifoValid)
                s_next.outWord = fifoWord;
        end

        // card indicators
        // lamps lag their inputs one cycle, like every output
        s_next.failLed   = !procReady;
        s_next.actGreen  = activeSel;
        s_next.stbyAmber = !activeSel;
    end

    // state register; fail indicator lit through reset
    // one wide register keeps outputs on flops, at some area cost
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg         <= '0;
            s_reg.scan    <= SC_HOLD;
            s_reg.stsCnt  <= CNT_RST;
            s_reg.vtCnt   <= CNT_RST;
            s_reg.scanVt  <= 5'h01;
            s_reg.failLed <= FAIL_LED_RST;
        end
        else if (ce)
            s_reg <= s_next;
    end

    // source maps: written only by accepted connect requests, kept in standby
    // no reset: enable bits guard every read, sparing a long clear
    always_ff @(posedge clk)
    begin
        if (ce && mapWrSts)
            stsSrc[cfgDstIdx[8:0]] <= cfgReq.srcPort;
        if (ce && mapWrVt)
            vtSrc[cfgDstIdx] <= cfgSrcIdx;
    end

    // latest byte of each incoming timeslot; bad addresses are dropped
    // a byte stored as it is scanned goes out with the old value
    always_ff @(posedge clk)
    begin
        if (ce && stsInValid && stsIn.port < 9'(STS_PORTS))
            stsData[stsIn.port] <= stsIn.data;
        if (ce && vtInValid && vtInOk)
            vtData[vtInIdx] <= vtIn.data;
    end

    // every top output straight from the state register
    assign cfgAck    = s_reg.cfgAck;
    assign cfgErr    = s_reg.cfgErr;
    assign outValid  = s_reg.outValid;
    assign outWord   = s_reg.outWord;
    assign failLed   = s_reg.failLed;
    assign actGreen  = s_reg.actGreen;
    assign stbyAmber = s_reg.stbyAmber;

endmodule // cxm_top

// >>> verification/cxm_checker.sv
// cxm_checker: port-level timing checks for the cross-connect top
// assumes one clk domain; bound into cxm_top below
`timescale 1ns/1ps
module cxm_checker
    import cxm_pkg::*;
(
    input wire logic      clk,
    input wire logic      rst_n,
    input wire logic      ce,
    input wire logic      cfgValid,
    input wire logic      cfgAck,
    input wire logic      cfgErr,
    input wire logic      outValid,
    input wire logic      outReady,
    input wire cxm_word_s outWord,
    input wire logic      procReady,
    input wire logic      activeSel,
    input wire logic      failLed,
    input wire logic      actGreen,
    input wire logic      stbyAmber
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // a setup request and its single answer one cycle on
    sequence s_req; cfgValid && ce; endsequence
    sequence s_ans; ##1 (cfgAck ^ cfgErr); endsequence
    property p_answer; s_req |-> s_ans; endproperty
    a_answer: assert property (p_answer) else $error("setup answer missing");
    property p_quiet; ce && !cfgValid |=> !cfgAck && !cfgErr; endproperty
    a_quiet: assert property (p_quiet) else $error("answer without request");
    // lamps lag their cause by one cycle; reset edge excluded by past rst_n
    property p_fail; $past(rst_n) && $past(ce) |-> failLed == !$past(procReady); endproperty
    a_fail: assert property (p_fail) else $error("fail lamp wrong");
    property p_green; $past(rst_n) && $past(ce) |-> actGreen == $past(activeSel); endproperty
    a_green: assert property (p_green) else $error("green lamp wrong");
    property p_amber; $rose(activeSel) && ce ##1 ce |-> !stbyAmber && actGreen; endproperty
    a_amber: assert property (p_amber) else $error("amber lamp wrong");
    // standby never drives traffic
    property p_standby; !activeSel && ce |=> !outValid; endproperty
    a_standby: assert property (p_standby) else $error("traffic in standby");
    property p_hold; outValid && !outReady && activeSel && ce |=> outValid && $stable(outWord); endproperty
    a_hold: assert property (p_hold) else $error("word not held");
    property p_group;
        outValid && outWord.isVt |-> outWord.group == 3'((outWord.vtNum - 5'h01) % 5'h07 + 5'h01)
            && outWord.position == 3'((outWord.vtNum - 5'h01) / 5'h07 + 5'h01);
    endproperty
    a_group: assert property (p_group) else $error("group or position wrong");
    property p_range;
        outValid |-> (outWord.isVt ? outWord.port < 9'h018 && outWord.vtNum > 5'h00
            && outWord.vtNum < 5'h1d : outWord.port < 9'h120);
    endproperty
    a_range: assert property (p_range) else $error("port out of range");
    c_vt: cover property (outValid && outWord.isVt);
endmodule // cxm_checker

bind cxm_top cxm_checker chk (.clk(clk), .rst_n(rst_n), .ce(ce), .cfgValid(cfgValid), .cfgAck(cfgAck),
    .cfgErr(cfgErr), .outValid(outValid), .outReady(outReady), .outWord(outWord), .procReady(procReady),
    .activeSel(activeSel), .failLed(failLed), .actGreen(actGreen), .stbyAmber(stbyAmber));

// >>> verification/cxm_sink.sv
// cxm_sink: traffic card taking switched words, ready only every other cycle
// assumes the bench reads got and drives stall
`timescale 1ns/1ps
module cxm_sink
    import cxm_pkg::*;
(
    input wire logic      clk,
    input wire logic      rst_n,
    input wire logic      stall,
    input wire logic      outValid,
    input wire cxm_word_s outWord,
    output logic          outReady
);
    cxm_word_s got[$];
    logic      beat;
    // half-rate ready: a real card is not always free
    always @(negedge clk or negedge rst_n)
        if (!rst_n)
        begin
            beat <= 1'b0;
            outReady <= 1'b0;
        end
        else
        begin
            beat <= !beat;
            outReady <= !stall && beat;
        end
    // words are taken only on a valid and ready edge
    always @(posedge clk)
        if (rst_n && outValid && outReady)
            got.push_back(outWord);
endmodule // cxm_sink

// >>> verification/tdm_cross_connect_matrix_test.sv
// tdm_cross_connect_matrix_test: scenario bench for cxm_top
// assumes cxm_sink as traffic card; the bench plays the controller
`timescale 1ns/1ps
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin fails++; \
    $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module tdm_cross_connect_matrix_test
    import cxm_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, cfgValid = 1'b0, stsInValid = 1'b0;
    logic        vtInValid = 1'b0, procReady = 1'b0, activeSel = 1'b0, stall = 1'b0;
    logic        cfgAck, cfgErr, outValid, outReady, failLed, actGreen, stbyAmber;
    cxm_cfg_s    cfgReq = '0;
    cxm_sts_in_s stsIn = '0;
    cxm_vt_in_s  vtIn = '0;
    cxm_word_s   outWord;
    int          fails = 0, totalChecks = 0;
    always #2 clk = !clk;
    cxm_top uut (.clk(clk), .rst_n(rst_n), .ce(ce), .cfgValid(cfgValid), .cfgReq(cfgReq), .cfgAck(cfgAck),
        .cfgErr(cfgErr), .stsInValid(stsInValid), .stsIn(stsIn), .vtInValid(vtInValid), .vtIn(vtIn),
        .outValid(outValid), .outReady(outReady), .outWord(outWord), .procReady(procReady),
        .activeSel(activeSel), .failLed(failLed), .actGreen(actGreen), .stbyAmber(stbyAmber));
    cxm_sink sink (.clk(clk), .rst_n(rst_n), .stall(stall), .outValid(outValid), .outWord(outWord),
        .outReady(outReady));

    task automatic give_verdict;
        if (fails == 0 && totalChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // one setup request, answer judged half a cycle after it is taken
    task automatic cfg(input logic v, c, input logic [3:0] s, input logic [8:0] dp, input logic [4:0] dv,
        input logic [8:0] sp, input logic [4:0] sv, input logic e);
        @(negedge clk);
        cfgValid = 1'b1;
        cfgReq = '{v, c, s, dp, dv, sp, sv};
        @(negedge clk);
        cfgValid = 1'b0;
        `CHK({cfgAck, cfgErr}, {!e, e})
    endtask
    task automatic sendByte(input logic v, input logic [8:0] p, input logic [4:0] n, input logic [7:0] d);
        @(negedge clk);
        stsInValid = !v;
        vtInValid = v;
        stsIn = '{p, d};
        vtIn = '{p[4:0], n, d};
        @(negedge clk);
        stsInValid = 1'b0;
        vtInValid = 1'b0;
    endtask
    // bounded wait for fresh words at the sink
    task automatic waitWords(input int n);
        sink.got.delete();
        for (int i = 0; i < 4000 && sink.got.size() < n; i++)
            @(negedge clk);
        `CHK(sink.got.size() >= n, 1'b1)
    endtask
    function automatic logic [3:0] slotOf(input int d);
        slotOf = d < 192 ? 4'(d / 48) : 4'(4 + (d - 192) / 12);
    endfunction

    task automatic t_leds;
        repeat (2) @(negedge clk);
        `CHK({failLed, actGreen, stbyAmber}, 3'h5)
        procReady = 1'b1;
        activeSel = 1'b1;
        repeat (2) @(negedge clk);
        `CHK({failLed, actGreen, stbyAmber}, 3'h2)
    endtask
    // every refused request leaves the maps empty
    task automatic t_refuse;
        cfg(0, 1, 4'h0, 9'd48, 0, 9'd1, 0, 1);
        cfg(0, 1, 4'h4, 9'd191, 0, 9'd1, 0, 1);
        cfg(0, 1, 4'hc, 9'd5, 0, 9'd1, 0, 1);
        cfg(0, 1, 4'h0, 9'd5, 0, 9'd288, 0, 1);
        cfg(1, 1, 4'h0, 9'd24, 5'd1, 9'd0, 5'd1, 1);
        cfg(1, 1, 4'h0, 9'd0, 5'd29, 9'd0, 5'd1, 1);
        cfg(1, 1, 4'h0, 9'd0, 5'd1, 9'd0, 5'd0, 1);
        sink.got.delete();
        repeat (1000) @(negedge clk);
        `CHK(sink.got.size(), 0)
    endtask
    // broadcast to slot boundary ports through a stalled card
    task automatic t_sts;
        sendByte(0, 9'd100, 0, 8'hab);
        cfg(0, 1, 4'h0, 9'd47, 0, 9'd100, 0, 0);
        cfg(0, 1, 4'hb, 9'd287, 0, 9'd100, 0, 0);
        stall = 1'b1;
        repeat (1200) @(negedge clk);
        `CHK(outValid, 1'b1)
        stall = 1'b0;
        waitWords(4);
        for (int i = 0; i < 4; i++)
            `CHK({sink.got[i].port === 9'd47 || sink.got[i].port === 9'd287, sink.got[i].data}, 9'h1ab)
        `CHK({sink.got[0].port !== sink.got[1].port, sink.got[0].port}, {1'b1, sink.got[2].port})
    endtask
    // standby keeps the map but drives nothing
    task automatic t_standby;
        activeSel = 1'b0;
        repeat (3) @(negedge clk);
        sink.got.delete();
        repeat (50)
        begin
            @(negedge clk);
            `CHK(outValid, 1'b0)
        end
        `CHK(sink.got.size(), 0)
        activeSel = 1'b1;
        waitWords(2);
        `CHK(sink.got[0].data, 8'hab)
    endtask
    // one tributary dropped to two positions, last group and position
    task automatic t_vt;
        cfg(0, 0, 4'h0, 9'd47, 0, 9'd0, 0, 0);
        cfg(0, 0, 4'hb, 9'd287, 0, 9'd0, 0, 0);
        sendByte(1, 9'd0, 5'd5, 8'h5c);
        cfg(1, 1, 4'h0, 9'd3, 5'd22, 9'd0, 5'd5, 0);
        cfg(1, 1, 4'h0, 9'd23, 5'd28, 9'd0, 5'd5, 0);
        repeat (1000) @(negedge clk);
        waitWords(2);
        for (int i = 0; i < 2; i++)
            `CHK({sink.got[i].isVt, sink.got[i].data, sink.got[i].port, sink.got[i].group, sink.got[i].position},
                {9'h15c, sink.got[i].vtNum === 5'd22 ? {9'd3, 3'd1, 3'd4} : {9'd23, 3'd7, 3'd4}})
        `CHK(sink.got[0].vtNum !== sink.got[1].vtNum, 1'b1)
    endtask
    // every STS destination taken at once: nothing blocks up to the limit
    task automatic t_fill;
        for (int d = 0; d < 288; d++)
            sendByte(0, 9'(d), 0, 8'(d));
        for (int d = 0; d < 288; d++)
            cfg(0, 1, slotOf(d), 9'(d), 0, 9'(287 - d), 0, 0);
        waitWords(8);
        for (int i = 0; i < 8; i++)
            `CHK(sink.got[i].data, sink.got[i].isVt ? 8'h5c : 8'(287 - sink.got[i].port))
    endtask
    // ce low freezes outValid, outWord and the fail and green lamps
    task automatic t_freeze;
        logic [31:0] held;
        ce = 1'b0;
        @(negedge clk);
        held = {outValid, outWord, failLed, actGreen};
        {procReady, activeSel} = 2'h0;
        repeat (20) @(negedge clk);
        `CHK({outValid, outWord, failLed, actGreen}, held)
        {ce, procReady, activeSel} = 3'h7;
        repeat (2) @(negedge clk);
        `CHK({failLed, actGreen, stbyAmber}, 3'h2)
    endtask

    initial
    begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        t_leds();
        t_refuse();
        t_sts();
        t_standby();
        t_vt();
        t_fill();
        t_freeze();
        give_verdict();
    end
    // hang guard, well beyond the roughly 6000 cycles the scenarios take
    initial
    begin
        #80000;
        fails++;
        give_verdict();
    end
endmodule // tdm_cross_connect_matrix_test
